// >>> hdl/srcr_pkg.sv
// package of offsets, fields and reset values for the readback/crc slice
package srcr_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_INPUT_SELECT = 8'h15;
  localparam logic [7:0] OFS_BAT_HIGH     = 8'h16;
  localparam logic [7:0] OFS_BAT_LOW      = 8'h17;
  localparam logic [7:0] OFS_BST_HIGH     = 8'h18;
  localparam logic [7:0] OFS_BST_LOW      = 8'h19;
  localparam logic [7:0] OFS_TMP1_HIGH    = 8'h1A;
  localparam logic [7:0] OFS_TMP1_LOW     = 8'h1B;
  localparam logic [7:0] OFS_TMP2_HIGH    = 8'h1C;
  localparam logic [7:0] OFS_TMP2_LOW     = 8'h1D;
  localparam logic [7:0] OFS_CRC_VALUE    = 8'h20;
  localparam logic [7:0] OFS_CRC_CLEAR    = 8'h21;
  localparam logic [7:0] OFS_DSP_BOOT     = 8'h22;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int         BIT_BAT_EN       = 2;
  localparam int         BIT_BST_EN       = 1;
  localparam int         BIT_TMP_EN       = 0;
  localparam int         BIT_CRC_CLEAR    = 0;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h04;
  localparam logic [7:0] RST_DSP_BOOT     = 8'h01;
  localparam logic [7:0] CRC_POLY         = 8'h07;
  localparam logic [7:0] CRC_INIT         = 8'h00;
  localparam logic [7:0] RD_UNMAPPED      = 8'h00;

  typedef enum logic [3:0] {
    BOOT_RESERVED  = 4'h0,
    BOOT_PCM_ONLY  = 4'h1,
    BOOT_PCM_SENSE = 4'h2,
    BOOT_PROTECT   = 4'h3,
    BOOT_PROT_VOICE= 4'h4
  } srcr_boot_t;

  typedef struct packed {
    logic [9:0] battery_result;
    logic [9:0] boost_result;
    logic [9:0] temp_one_result;
    logic [9:0] temp_two_result;
  } srcr_results_t;

  typedef struct packed {
    logic [7:0]    input_select;
    logic [7:0]    dsp_boot;
    logic [7:0]    crc_reserved;
    logic [7:0]    checksum_value;
    srcr_results_t results;
    logic [7:0]    rdata;
  } srcr_state_t;
endpackage

// >>> hdl/srcr_regs.sv
// register slice: converter input select, result readback, crc, dsp boot
`timescale 1ns/1ps
module srcr_regs (
  input  wire logic                   MCLK,           // 50 MHz clock
  input  wire logic                   RESETN,         // async reset, low
  input  wire logic                   CLK_EN,         // freezes state when low
  input  wire logic                   REG_WR,         // write strobe
  input  wire logic                   REG_RD,         // read strobe
  input  wire logic [7:0]             REG_ADDR,       // register address
  input  wire logic [7:0]             REG_WDATA,      // write data
  output logic      [7:0]             REG_RDATA,      // read data
  input  wire logic                   BUS_BYTE_VALID, // bus data byte seen
  input  wire logic [7:0]             BUS_BYTE,       // bus data byte
  input  wire logic                   READBACK_FREEZE,// halt result updates
  input  wire logic                   CONV_DONE,      // conversion finished
  input  wire srcr_pkg::srcr_results_t CONV_RESULTS,  // new results
  output logic                        BATTERY_SAMPLE_ENABLE,     // to adc
  output logic                        BOOST_SAMPLE_ENABLE,       // to adc
  output logic                        TEMPERATURE_SAMPLE_ENABLE, // to adc
  output logic      [3:0]             DSP_BOOT_MODE,  // boot selector
  output logic                        DSP_BOOT_VALID  // boot code within 1 to 4
);
  srcr_pkg::srcr_state_t st_reg;
  srcr_pkg::srcr_state_t st_next;

  // ****************************************
  // crc step over one byte
  // ****************************************
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ srcr_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    if (REG_WR && REG_ADDR == srcr_pkg::OFS_INPUT_SELECT) begin
      st_next.input_select = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == srcr_pkg::OFS_DSP_BOOT) begin
      st_next.dsp_boot = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == srcr_pkg::OFS_CRC_CLEAR) begin
      st_next.crc_reserved = {REG_WDATA[7:1], 1'b0};
    end
    // clear wins over byte in same cycle: cleared state is what sw asked
    if (REG_WR && REG_ADDR == srcr_pkg::OFS_CRC_CLEAR
        && REG_WDATA[srcr_pkg::BIT_CRC_CLEAR]) begin
      st_next.checksum_value = srcr_pkg::CRC_INIT;
    end else if (BUS_BYTE_VALID) begin
      st_next.checksum_value =
        crc_step(st_reg.checksum_value, BUS_BYTE);
    end
    if (CONV_DONE && !READBACK_FREEZE) begin
      st_next.results = CONV_RESULTS;
    end
    if (REG_RD) begin
      case (REG_ADDR)
        srcr_pkg::OFS_INPUT_SELECT: st_next.rdata = st_reg.input_select;
        srcr_pkg::OFS_BAT_HIGH:
          st_next.rdata = st_reg.results.battery_result[9:2];
        srcr_pkg::OFS_BAT_LOW:
          st_next.rdata = {st_reg.results.battery_result[1:0],
                           6'h00};
        srcr_pkg::OFS_BST_HIGH:
          st_next.rdata = st_reg.results.boost_result[9:2];
        srcr_pkg::OFS_BST_LOW:
          st_next.rdata = {st_reg.results.boost_result[1:0],
                           6'h00};
        srcr_pkg::OFS_TMP1_HIGH:
          st_next.rdata = st_reg.results.temp_one_result[9:2];
        srcr_pkg::OFS_TMP1_LOW:
          st_next.rdata = {st_reg.results.temp_one_result[1:0],
                           6'h00};
        srcr_pkg::OFS_TMP2_HIGH:
          st_next.rdata = st_reg.results.temp_two_result[9:2];
        srcr_pkg::OFS_TMP2_LOW:
          st_next.rdata = {st_reg.results.temp_two_result[1:0],
                           6'h00};
        srcr_pkg::OFS_CRC_VALUE:
          st_next.rdata = st_reg.checksum_value;
        srcr_pkg::OFS_CRC_CLEAR:  st_next.rdata = st_reg.crc_reserved;
        srcr_pkg::OFS_DSP_BOOT:   st_next.rdata = st_reg.dsp_boot;
        default:                  st_next.rdata = srcr_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg              <= '0;
      st_reg.input_select <= srcr_pkg::RST_INPUT_SELECT;
      st_reg.dsp_boot     <= srcr_pkg::RST_DSP_BOOT;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign REG_RDATA                 = st_reg.rdata;
  assign BATTERY_SAMPLE_ENABLE     =
    st_reg.input_select[srcr_pkg::BIT_BAT_EN];
  assign BOOST_SAMPLE_ENABLE       =
    st_reg.input_select[srcr_pkg::BIT_BST_EN];
  assign TEMPERATURE_SAMPLE_ENABLE =
    st_reg.input_select[srcr_pkg::BIT_TMP_EN];
  assign DSP_BOOT_MODE             = st_reg.dsp_boot[3:0];
  assign DSP_BOOT_VALID            =
    (st_reg.dsp_boot[3:0] >= 4'(srcr_pkg::BOOT_PCM_ONLY)) &&
    (st_reg.dsp_boot[3:0] <= 4'(srcr_pkg::BOOT_PROT_VOICE));

  // ****************************************
  // assertions
  // ****************************************
  a_freeze_holds: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && READBACK_FREEZE |=> $stable(st_reg.results))
    else $error("results changed while frozen");

  a_idle_results: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && !CONV_DONE |=> $stable(st_reg.results))
    else $error("results changed without a conversion");

  a_conv_loads: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && CONV_DONE && !READBACK_FREEZE
    |=> st_reg.results == $past(CONV_RESULTS))
    else $error("conversion not captured whole");

  a_ro_ignore: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_WR && REG_ADDR == srcr_pkg::OFS_BAT_HIGH && !CONV_DONE
    |=> $stable(st_reg.results))
    else $error("write to a result register took effect");

  a_crc_clear: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_WR && REG_ADDR == srcr_pkg::OFS_CRC_CLEAR
    && REG_WDATA[srcr_pkg::BIT_CRC_CLEAR]
    |=> st_reg.checksum_value == 8'h00 && !st_reg.crc_reserved[0])
    else $error("checksum not cleared");

  a_clear_read: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_CRC_CLEAR
    |=> !REG_RDATA[0])
    else $error("checksum clear bit did not clear itself");

  a_crc_absorb: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && BUS_BYTE_VALID
    && !(REG_WR && REG_ADDR == srcr_pkg::OFS_CRC_CLEAR)
    |=> st_reg.checksum_value
        == crc_step($past(st_reg.checksum_value), $past(BUS_BYTE)))
    else $error("checksum step wrong");

  a_crc_hold: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && !BUS_BYTE_VALID
    && !(REG_WR && REG_ADDR == srcr_pkg::OFS_CRC_CLEAR)
    |=> $stable(st_reg.checksum_value))
    else $error("checksum moved without a bus byte");

  a_crc_read: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_CRC_VALUE
    |=> REG_RDATA == $past(st_reg.checksum_value))
    else $error("checksum readback wrong");

  a_bat_high: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_BAT_HIGH
    |=> REG_RDATA == $past(st_reg.results.battery_result[9:2]))
    else $error("battery high byte wrong");

  a_bat_low: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_BAT_LOW
    |=> REG_RDATA == {$past(st_reg.results.battery_result[1:0]), 6'h00})
    else $error("battery low byte wrong");

  a_bst_high: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_BST_HIGH
    |=> REG_RDATA == $past(st_reg.results.boost_result[9:2]))
    else $error("boost high byte wrong");

  a_bst_low: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_BST_LOW
    |=> REG_RDATA == {$past(st_reg.results.boost_result[1:0]), 6'h00})
    else $error("boost low byte wrong");

  a_tmp1_high: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_TMP1_HIGH
    |=> REG_RDATA == $past(st_reg.results.temp_one_result[9:2]))
    else $error("first temperature high byte wrong");

  a_tmp1_low: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_TMP1_LOW
    |=> REG_RDATA == {$past(st_reg.results.temp_one_result[1:0]), 6'h00})
    else $error("first temperature low byte wrong");

  a_tmp2_high: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_TMP2_HIGH
    |=> REG_RDATA == $past(st_reg.results.temp_two_result[9:2]))
    else $error("second temperature high byte wrong");

  a_tmp2_low: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_TMP2_LOW
    |=> REG_RDATA == {$past(st_reg.results.temp_two_result[1:0]), 6'h00})
    else $error("second temperature low byte wrong");

  a_bat_enable: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_WR && REG_ADDR == srcr_pkg::OFS_INPUT_SELECT
    |=> BATTERY_SAMPLE_ENABLE == $past(REG_WDATA[srcr_pkg::BIT_BAT_EN]))
    else $error("battery enable not written");

  a_bst_enable: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_WR && REG_ADDR == srcr_pkg::OFS_INPUT_SELECT
    |=> BOOST_SAMPLE_ENABLE == $past(REG_WDATA[srcr_pkg::BIT_BST_EN]))
    else $error("boost enable not written");

  a_tmp_enable: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_WR && REG_ADDR == srcr_pkg::OFS_INPUT_SELECT
    |=> TEMPERATURE_SAMPLE_ENABLE == $past(REG_WDATA[srcr_pkg::BIT_TMP_EN]))
    else $error("temperature enable not written");

  a_sel_read: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_INPUT_SELECT
    |=> REG_RDATA == $past(st_reg.input_select))
    else $error("input select readback wrong");

  a_boot_write: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_WR && REG_ADDR == srcr_pkg::OFS_DSP_BOOT
    |=> DSP_BOOT_MODE == $past(REG_WDATA[3:0]))
    else $error("boot mode not written");

  a_boot_read: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    CLK_EN && REG_RD && REG_ADDR == srcr_pkg::OFS_DSP_BOOT
    |=> REG_RDATA == $past(st_reg.dsp_boot))
    else $error("boot control readback wrong");

  a_boot_valid: assert property (
    @(posedge MCLK) disable iff (!RESETN)
    DSP_BOOT_VALID == (DSP_BOOT_MODE inside {4'h1, 4'h2, 4'h3, 4'h4}))
    else $error("boot code validity wrong");

  // ****************************************
  // covers
  // ****************************************
  c_freeze_read: cover property (
    @(posedge MCLK) disable iff (!RESETN)
    READBACK_FREEZE && CONV_DONE ##1 REG_RD);

  c_crc_clear: cover property (
    @(posedge MCLK) disable iff (!RESETN)
    BUS_BYTE_VALID ##1 REG_WR && REG_ADDR == srcr_pkg::OFS_CRC_CLEAR);

  c_conv_load: cover property (
    @(posedge MCLK) disable iff (!RESETN)
    CONV_DONE && !READBACK_FREEZE);

  c_clear_on_byte: cover property (
    @(posedge MCLK) disable iff (!RESETN)
    BUS_BYTE_VALID && REG_WR && REG_ADDR == srcr_pkg::OFS_CRC_CLEAR);

  c_boot_reserved: cover property (
    @(posedge MCLK) disable iff (!RESETN)
    !DSP_BOOT_VALID);
endmodule

// >>> verif/srcr_host.sv
// host model driving the register strobes of the readback/crc slice
`timescale 1ns/1ps
module srcr_host (
  input  wire logic       mclk,  // register clock
  input  wire logic [7:0] rdata, // read data from device
  output logic            wr,    // write strobe
  output logic            rd,    // read strobe
  output logic [7:0]      addr,  // register address
  output logic [7:0]      wdata  // write data
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // idle address and data are inverted, never left at the last value
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    {wr, addr, wdata} = {1'b1, a, d};
    @(posedge mclk);
    #1;
    {wr, addr, wdata} = {1'b0, ~a, ~d};
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    {rd, addr} = {1'b1, a};
    @(posedge mclk);
    #1;
    {rd, addr} = {1'b0, ~a};
    d = rdata;
  endtask
  // checksum cleared before a program download
  task automatic clear_sum;
    put(srcr_pkg::OFS_CRC_CLEAR, 8'h01);
  endtask
endmodule

// >>> verif/sar_readback_crc_regs_test.sv
// self-checking bench for the readback/crc register slice
`timescale 1ns/1ps
module sar_readback_crc_regs_test;
  logic                    MCLK, RESETN, REG_WR, REG_RD, BUS_BYTE_VALID;
  logic                    READBACK_FREEZE, CONV_DONE, BAT_EN, BST_EN, TMP_EN;
  logic                    DSP_BOOT_VALID, CLK_EN;
  logic [7:0]              REG_ADDR, REG_WDATA, REG_RDATA, BUS_BYTE, rd_val;
  logic [3:0]              DSP_BOOT_MODE;
  srcr_pkg::srcr_results_t CONV_RESULTS;
  int                      fail_count, checked;
  srcr_regs dut_u (.MCLK(MCLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .BUS_BYTE(BUS_BYTE),
    .BUS_BYTE_VALID(BUS_BYTE_VALID), .READBACK_FREEZE(READBACK_FREEZE),
    .CONV_DONE(CONV_DONE), .CONV_RESULTS(CONV_RESULTS),
    .BATTERY_SAMPLE_ENABLE(BAT_EN), .BOOST_SAMPLE_ENABLE(BST_EN),
    .TEMPERATURE_SAMPLE_ENABLE(TMP_EN), .DSP_BOOT_MODE(DSP_BOOT_MODE),
    .DSP_BOOT_VALID(DSP_BOOT_VALID));
  srcr_host host_u (.mclk(MCLK), .rdata(REG_RDATA), .wr(REG_WR), .rd(REG_RD),
    .addr(REG_ADDR), .wdata(REG_WDATA));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction
  task automatic reset_check;
    for (int i = 8'h15; i <= 8'h23; i++) begin
      host_u.get(8'(i), rd_val);
      chk(rd_val, i == 8'h15 ? 8'h04 : i == 8'h22 ? 8'h01 : 8'h00);
    end
    chk({BAT_EN, BST_EN, TMP_EN, DSP_BOOT_VALID, DSP_BOOT_MODE}, 8'h91);
  endtask
  task automatic select_check;
    host_u.put(8'h15, 8'hFB);
    chk({5'h00, BAT_EN, BST_EN, TMP_EN}, 8'h03);
    host_u.get(8'h15, rd_val);
    chk(rd_val, 8'hFB);
    host_u.put(8'h15, 8'h04);
    chk({5'h00, BAT_EN, BST_EN, TMP_EN}, 8'h04);
  endtask
  task automatic conv(input logic [39:0] r);
    @(posedge MCLK);
    #1;
    {CONV_DONE, CONV_RESULTS} = {1'b1, r};
    @(posedge MCLK);
    #1;
    {CONV_DONE, CONV_RESULTS} = {1'b0, ~r};
  endtask
  // high byte then low byte of each of the four results
  task automatic read_results(input logic [39:0] r);
    logic [9:0] v;
    for (int k = 0; k < 4; k++) begin
      v = r[39-10*k -: 10];
      host_u.get(8'h16 + 8'(2*k), rd_val);
      chk(rd_val, v[9:2]);
      host_u.get(8'h17 + 8'(2*k), rd_val);
      chk(rd_val, {v[1:0], 6'h00});
    end
  endtask
  task automatic results_check;
    conv(40'hA55A3CC396);
    read_results(40'hA55A3CC396);
    READBACK_FREEZE = 1'b1;
    host_u.put(8'h16, 8'hFF);
    conv(40'h5AA5C33C69);
    read_results(40'hA55A3CC396);
    READBACK_FREEZE = 1'b0;
    conv(40'h5AA5C33C69);
    read_results(40'h5AA5C33C69);
  endtask
  task automatic crc_check;
    logic [7:0] m;
    host_u.clear_sum();
    m = 8'h00;
    for (int i = 0; i < 5; i++) begin
      @(posedge MCLK);
      #1;
      {BUS_BYTE_VALID, BUS_BYTE} = {1'b1, 8'(i * 37 + 3)};
      m = crc8(m, BUS_BYTE);
    end
    @(posedge MCLK);
    #1;
    {BUS_BYTE_VALID, BUS_BYTE} = {1'b0, ~BUS_BYTE};
    host_u.get(8'h20, rd_val);
    chk(rd_val, m);
    // clear write and a bus byte in one cycle: the clear wins
    fork
      host_u.put(8'h21, 8'hFF);
      begin
        @(posedge MCLK);
        #1;
        {BUS_BYTE_VALID, BUS_BYTE} = {1'b1, 8'h5A};
        @(posedge MCLK);
        #1;
        {BUS_BYTE_VALID, BUS_BYTE} = {1'b0, 8'hA5};
      end
    join
    host_u.get(8'h21, rd_val);
    chk(rd_val, 8'hFE);
    host_u.get(8'h20, rd_val);
    chk(rd_val, 8'h00);
  endtask
  task automatic boot_check;
    for (int c = 0; c < 6; c++) begin
      host_u.put(8'h22, 8'hF0 | 8'(c));
      chk({3'h0, DSP_BOOT_VALID, DSP_BOOT_MODE},
          {3'h0, 1'(c >= 1 && c <= 4), 4'(c)});
    end
    host_u.get(8'h22, rd_val);
    chk(rd_val, 8'hF5);
  endtask
  // clock enable low: writes and conversions are held off
  task automatic enable_check;
    CLK_EN = 1'b0;
    host_u.put(8'h22, 8'h03);
    conv(40'h0123456789);
    chk({4'h0, DSP_BOOT_MODE}, 8'h05);
    CLK_EN = 1'b1;
    host_u.get(8'h22, rd_val);
    chk(rd_val, 8'hF5);
    read_results(40'h5AA5C33C69);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    fail_count++;
    summarize();
  end
  initial begin
    {RESETN, BUS_BYTE_VALID, BUS_BYTE, READBACK_FREEZE, CONV_DONE} = '0;
    CONV_RESULTS = '0;
    CLK_EN = 1'b1;
    {fail_count, checked} = '0;
    repeat (8) @(posedge MCLK);
    #1 RESETN = 1'b1;
    reset_check();
    select_check();
    results_check();
    crc_check();
    boot_check();
    enable_check();
    summarize();
  end
endmodule
